// File: vc_resource_regs_bench.sv
`timescale 1ns/1ps
module vc_resource_regs_bench
  import vcr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic mgmt_wr = 1'b0;
  logic [6:0] mgmt_time_slots = 7'h00;
  logic [7:0] mgmt_map = 8'h00;
  logic negotiating = 1'b0;
  logic [PHASE_W-1:0] arb_phase = '0;
  logic [1:0] arb_port;
  logic [7:0] tc_map;
  logic [2:0] arb_scheme;
  logic channel_enable;
  logic table_loading;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  integer seed = 32'hf5b0;
  logic [31:0] rd;
  logic [31:0] last;
  logic [31:0] tw [8];

  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  vcr_sw_model sw (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  vcr_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mgmt_wr(mgmt_wr), .mgmt_time_slots(mgmt_time_slots),
    .mgmt_traffic_class_channel_map(mgmt_map), .negotiating(negotiating),
    .arb_phase(arb_phase), .arb_port(arb_port), .traffic_class_channel_map(tc_map),
    .arb_scheme(arb_scheme), .channel_enable(channel_enable),
    .table_loading(table_loading));

  // ------------------------------------------------------------------
  // Expectations and reporting
  // ------------------------------------------------------------------
  function automatic logic [31:0] ctrl_exp(input logic [31:0] wd);
    logic [2:0] sel;
    sel = (wd[19:17] == SEL_ALT) ? SEL_ALT : SEL_DEF;
    return {wd[31], 4'h0, ID_VAL, 4'h0, sel, 1'b0, 8'h00, wd[7:0]};
  endfunction

  function automatic logic [31:0] cap_exp(input logic [6:0] slots);
    return {8'h04, 1'b0, slots, 2'b00, 6'h00, 8'h09};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    logic [6:0] slots;
    logic [6:0] p;
    int n;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    sw.rd_word(CAP_OFS, rd);
    check("capability", rd, 32'h047F0009);
    sw.rd_word(CTRL_OFS, rd);
    check("control", rd, 32'h800000FF);
    sw.rd_word(STAT_OFS, rd);
    check("status", rd, 32'h00000000);
    $display("test reset values done");

    sw.wr_word(CAP_OFS, 32'hFFFFFFFF);
    sw.wr_word(STAT_OFS, 32'hFFFFFFFF);
    sw.wr_word(12'h15C, 32'hFFFFFFFF);
    sw.rd_word(CAP_OFS, rd);
    check("capability", rd, 32'h047F0009);
    sw.rd_word(STAT_OFS, rd);
    check("status", rd, 32'h00000000);
    sw.rd_word(12'h15C, rd);
    check("unmapped", rd, 32'h00000000);
    $display("test read-only done");

    for (int s = 0; s < 8; s++)
    begin
      last = $random(seed);
      last[19:17] = s[2:0];
      last[16] = 1'b0;
      last[31] = s[0];
      sw.wr_word(CTRL_OFS, last);
      sw.rd_word(CTRL_OFS, rd);
      check("control", rd, ctrl_exp(last));
      check("scheme", {29'h0, arb_scheme},
        {29'h0, ((last[19:17] == SEL_ALT) ? SEL_ALT : SEL_DEF)});
      check("map", {24'h0, tc_map}, {24'h0, last[7:0]});
      check("enable", {31'h0, channel_enable}, {31'h0, last[31]});
    end
    $display("test control done");

    slots = 7'($random(seed));
    @(posedge ref_clk);
    mgmt_wr <= 1'b1;
    mgmt_time_slots <= slots;
    mgmt_map <= 8'($random(seed));
    @(posedge ref_clk);
    mgmt_wr <= 1'b0;
    last[7:0] = mgmt_map;
    sw.rd_word(CAP_OFS, rd);
    check("capability", rd, cap_exp(slots));
    sw.rd_word(CTRL_OFS, rd);
    check("control", rd, ctrl_exp(last));
    $display("test sideband done");

    for (int k = 0; k < 8; k++)
    begin
      tw[k] = $random(seed);
      sw.wr_word(TBL_OFS + 12'(4 * k), tw[k]);
    end
    sw.rd_word(STAT_OFS, rd);
    check("status", rd, 32'h00010000);
    sw.rd_word(TBL_OFS + 12'h00C, rd);
    check("table word", rd, tw[3]);
    sw.wr_word(CTRL_OFS, last | 32'h00010000);
    sw.rd_word(CTRL_OFS, rd);
    check("control", rd, ctrl_exp(last));
    check("loading", {31'h0, table_loading}, 32'h1);
    n = 0;
    while (table_loading !== 1'b0 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    sw.rd_word(STAT_OFS, rd);
    check("status", rd, 32'h00000000);
    for (int i = 0; i < 128; i++)
    begin
      p = i[6:0];
      @(posedge ref_clk);
      arb_phase <= p;
      @(posedge ref_clk);
      #1;
      check("port", {30'h0, arb_port}, {30'h0, tw[p[6:4]][{p[3:0], 1'b0} +: 2]});
    end
    $display("test table load done");

    @(posedge ref_clk);
    negotiating <= 1'b1;
    sw.rd_word(STAT_OFS, rd);
    check("status", rd, 32'h00020000);
    @(posedge ref_clk);
    negotiating <= 1'b0;
    sw.rd_word(STAT_OFS, rd);
    check("status", rd, 32'h00000000);
    $display("test negotiation done");

    // A write while the clock enable is low must leave every field alone.
    @(posedge ref_clk);
    ce <= 1'b0;
    sw.wr_word(CTRL_OFS, 32'h00000000);
    @(posedge ref_clk);
    ce <= 1'b1;
    sw.rd_word(CTRL_OFS, rd);
    check("frozen control", rd, ctrl_exp(last));
    check("frozen enable", {31'h0, channel_enable}, 32'h1);
    $display("test clock enable done");
    print_verdict();
  end
endmodule

// File: vcr_pkg.sv
package vcr_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] CAP_OFS = 12'h150;
  localparam logic [11:0] CTRL_OFS = 12'h154;
  localparam logic [11:0] STAT_OFS = 12'h158;
  localparam logic [11:0] TBL_OFS = 12'h180;
  localparam int TBL_SEL_LSB = 5;
  localparam int WORD_LSB = 2;
  localparam int TBL_IDX_W = 3;

  // ------------------------------------------------------------------
  // Arbitration table shape
  // ------------------------------------------------------------------
  localparam int ENTRIES = 128;
  localparam int ENTRY_W = 2;
  localparam int PHASE_W = 7;

  // ------------------------------------------------------------------
  // Capability fields
  // ------------------------------------------------------------------
  localparam int PAC_LSB = 0;
  localparam logic [7:0] PAC_RST = 8'h09;
  localparam int AS_BIT = 14;
  localparam int RSNP_BIT = 15;
  localparam int SLOTS_LSB = 16;
  localparam logic [6:0] SLOTS_RST = 7'h7F;
  localparam int TOFS_LSB = 24;
  localparam logic [7:0] TOFS_RST = 8'h04;

  // ------------------------------------------------------------------
  // Control and status fields
  // ------------------------------------------------------------------
  localparam int MAP_LSB = 0;
  localparam logic [7:0] MAP_RST = 8'hFF;
  localparam int LOAD_BIT = 16;
  localparam int SEL_LSB = 17;
  localparam logic [2:0] SEL_DEF = 3'h0;
  localparam logic [2:0] SEL_ALT = 3'h3;
  localparam int ID_LSB = 24;
  localparam logic [2:0] ID_VAL = 3'h0;
  localparam int EN_BIT = 31;
  localparam logic EN_RST = 1'b1;
  localparam int TSTAT_BIT = 16;
  localparam int PEND_BIT = 17;

  typedef enum logic [0:0] {
    LD_IDLE = 1'b0,
    LD_COPY = 1'b1
  } vcr_ld_state_type;

endpackage

// File: vcr_regs.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
// How it works
// - Capability bits 7:0 read fixed 09h: round robin and weighted, 128 phases.
// - Capability bit 14 reads zero; no switch-fabric-only restriction.
// - Capability bit 15, snoop rejection, reads zero.
// - Capability bits 22:16 give time slots minus one; reset 7Fh, sideband may override.
// - Capability bits 31:24 give table offset in 16-byte units, value 04h.
// - Control bits 7:0 map traffic classes; reset FFh, sideband may override.
// - Writing one to control bit 16 loads the table; it reads zero.
// - Scheme select bits 19:17 keep 000b or 011b; other values become 000b.
// - Control bits 26:24 read a fixed channel identifier 000b.
// - Control bit 31 enables the channel; it resets to one.
// - Any software write of a table entry sets status bit 16.
// - Status bit 16 clears when the table load finishes.
// - Status bit 17 shows negotiation pending; resets to zero.
// - The table holds 128 two-bit port numbers, one per phase.
module vcr_regs
  import vcr_pkg::*;
#(
  parameter int N = ENTRIES,
  parameter int EW = ENTRY_W
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic mgmt_wr,
  input wire logic [6:0] mgmt_time_slots,
  input wire logic [7:0] mgmt_traffic_class_channel_map,
  input wire logic negotiating,
  input wire logic [PHASE_W-1:0] arb_phase,
  output logic [1:0] arb_port,
  output logic [7:0] traffic_class_channel_map,
  output logic [2:0] arb_scheme,
  output logic channel_enable,
  output logic table_loading
);

  localparam int TBL_BITS = N * EW;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] map;
    logic [2:0] scheme;
    logic enable;
    logic [6:0] slots;
    logic tbl_status;
    logic pending;
    logic [DATA_W-1:0] rdata;
    logic [TBL_BITS-1:0] stored;
    logic [TBL_BITS-1:0] active;
    logic [EW-1:0] port;
    logic loading;
  } vcr_state_type;

  vcr_state_type s_r;
  vcr_state_type s_nxt;

  logic hit_cap;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_tbl;
  logic [TBL_IDX_W-1:0] word_idx;
  logic tbl_wr;
  logic load_req;
  logic ld_busy;
  logic [PHASE_W-1:0] ld_idx;
  logic ld_done;
  logic [DATA_W-1:0] cap_word;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] stat_word;
  logic [2:0] sel_in;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  assign hit_cap = (reg_addr == CAP_OFS);
  assign hit_ctrl = (reg_addr == CTRL_OFS);
  assign hit_stat = (reg_addr == STAT_OFS);
  assign hit_tbl = (reg_addr[ADDR_W-1:TBL_SEL_LSB] == TBL_OFS[ADDR_W-1:TBL_SEL_LSB]) &&
                   (reg_addr[WORD_LSB-1:0] == 2'h0);
  assign word_idx = reg_addr[WORD_LSB +: TBL_IDX_W];
  assign tbl_wr = reg_wr && hit_tbl;
  assign load_req = reg_wr && hit_ctrl && reg_wdata[LOAD_BIT];
  assign sel_in = reg_wdata[SEL_LSB +: 3];

  // ------------------------------------------------------------------
  // Read views
  // ------------------------------------------------------------------
  // Reserved bits zero
  always_comb
  begin
    cap_word = '0;
    cap_word[PAC_LSB +: 8] = PAC_RST;
    cap_word[AS_BIT] = 1'b0;
    cap_word[RSNP_BIT] = 1'b0;
    cap_word[SLOTS_LSB +: 7] = s_r.slots;
    cap_word[TOFS_LSB +: 8] = TOFS_RST;
  end

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[MAP_LSB +: 8] = s_r.map;
    ctrl_word[LOAD_BIT] = 1'b0;
    ctrl_word[SEL_LSB +: 3] = s_r.scheme;
    ctrl_word[ID_LSB +: 3] = ID_VAL;
    ctrl_word[EN_BIT] = s_r.enable;
  end

  always_comb
  begin
    stat_word = '0;
    stat_word[TSTAT_BIT] = s_r.tbl_status;
    stat_word[PEND_BIT] = s_r.pending;
  end

  // ------------------------------------------------------------------
  // Table loader
  // ------------------------------------------------------------------
  // The copy runs one entry per cycle, so during a load the arbiter sees
  // a partly updated table word; the price is 128 cycles per load.
  vcr_table_load #(
    .N(N),
    .IW(PHASE_W)
  ) u_load (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(load_req),
    .busy(ld_busy),
    .idx(ld_idx),
    .done(ld_done)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    s_nxt.loading = ld_busy;
    if (reg_wr && hit_ctrl)
    begin
      s_nxt.map = reg_wdata[MAP_LSB +: 8];
      if (sel_in == SEL_ALT)
      begin
        s_nxt.scheme = SEL_ALT;
      end
      else
      begin
        s_nxt.scheme = SEL_DEF;
      end
      s_nxt.enable = reg_wdata[EN_BIT];
    end
    // Sideband loads come after software so the strap image wins a tie.
    if (mgmt_wr)
    begin
      s_nxt.slots = mgmt_time_slots;
      s_nxt.map = mgmt_traffic_class_channel_map;
    end
    if (tbl_wr)
    begin
      s_nxt.stored[word_idx*DATA_W +: DATA_W] = reg_wdata;
    end
    if (ld_busy)
    begin
      s_nxt.active[ld_idx*EW +: EW] = s_r.stored[ld_idx*EW +: EW];
    end
    if (ld_done)
    begin
      s_nxt.tbl_status = 1'b0;
    end
    if (tbl_wr)
    begin
      s_nxt.tbl_status = 1'b1;
    end
    s_nxt.pending = negotiating;
    s_nxt.port = s_r.active[arb_phase*EW +: EW];
    if (reg_rd)
    begin
      if (hit_cap)
      begin
        s_nxt.rdata = cap_word;
      end
      else if (hit_ctrl)
      begin
        s_nxt.rdata = ctrl_word;
      end
      else if (hit_stat)
      begin
        s_nxt.rdata = stat_word;
      end
      else if (hit_tbl)
      begin
        s_nxt.rdata = s_r.stored[word_idx*DATA_W +: DATA_W];
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r.map <= MAP_RST;
      s_r.scheme <= SEL_DEF;
      s_r.enable <= EN_RST;
      s_r.slots <= SLOTS_RST;
      s_r.tbl_status <= 1'b0;
      s_r.pending <= 1'b0;
      s_r.rdata <= '0;
      s_r.stored <= '0;
      s_r.active <= '0;
      s_r.port <= '0;
      s_r.loading <= 1'b0;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign arb_port = s_r.port;
  assign traffic_class_channel_map = s_r.map;
  assign arb_scheme = s_r.scheme;
  assign channel_enable = s_r.enable;
  assign table_loading = s_r.loading;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  cap_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_rd && hit_cap |=> reg_rdata[15:0] == 16'h0009)
    else $error("capability low half wrong");

  cap_offset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_rd && hit_cap |=> reg_rdata[31:23] == 9'h008)
    else $error("table offset field wrong");

  load_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_rd && hit_ctrl |=> reg_rdata[16] == 1'b0 && reg_rdata[30:20] == 11'h000)
    else $error("control trigger or reserved bits not zero");

  scheme_legal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_wr && hit_ctrl && !mgmt_wr |=>
      arb_scheme == ($past(reg_wdata[19:17]) == 3'h3 ? 3'h3 : 3'h0))
    else $error("scheme select not filtered");

  enable_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_wr && hit_ctrl |=> channel_enable == $past(reg_wdata[31]))
    else $error("channel enable not written");

  tbl_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && tbl_wr |=> s_r.tbl_status)
    else $error("table write did not set status");

  tbl_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && ld_done && !tbl_wr |=> !s_r.tbl_status)
    else $error("load end did not clear status");

  pend_track_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce |=> s_r.pending == $past(negotiating))
    else $error("pending flag does not track negotiation");

  stat_res_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_rd && hit_stat |=> reg_rdata[15:0] == 16'h0000 && reg_rdata[31:18] == 14'h0000)
    else $error("status reserved bits not zero");

  load_span_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && load_req ##1 ce [*8] |-> ld_busy)
    else $error("table copy ended too early");

  fabric_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_rd && hit_cap |=> reg_rdata[14] == 1'b0)
    else $error("fabric-only flag not zero");

  snoop_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_rd && hit_cap |=> reg_rdata[15] == 1'b0)
    else $error("snoop rejection flag not zero");

  slots_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && mgmt_wr |=> s_r.slots == $past(mgmt_time_slots))
    else $error("sideband slot count not taken");

  map_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_wr && hit_ctrl && !mgmt_wr |=> traffic_class_channel_map == $past(reg_wdata[7:0]))
    else $error("traffic class map not written");

  map_mgmt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && mgmt_wr |=> traffic_class_channel_map == $past(mgmt_traffic_class_channel_map))
    else $error("sideband traffic class map not taken");

  load_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && load_req |=> ld_busy && ld_idx == '0)
    else $error("table copy did not start at entry zero");

  chan_id_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_rd && hit_ctrl |=> reg_rdata[26:24] == 3'h0)
    else $error("channel identifier not fixed");

  ro_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_wr && hit_cap && !mgmt_wr |=> $stable(s_r.slots))
    else $error("read-only slot count changed by write");

  unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && reg_rd && !hit_cap && !hit_ctrl && !hit_stat && !hit_tbl |=> reg_rdata == '0)
    else $error("unmapped read not zero");

endmodule

// File: vcr_sw_model.sv
`timescale 1ns/1ps
module vcr_sw_model
  import vcr_pkg::*;
(
  input wire logic ref_clk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  initial
  begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ------------------------------------------------------------------
  // Configuration accesses
  // ------------------------------------------------------------------
  // The address, and after a write the data, are inverted once the strobe drops, so a design that
  // samples them outside the strobe cycle sees garbage, not a stale value.
  // one-cycle write strobe
  task automatic wr_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// File: vcr_table_load.sv
`timescale 1ns/1ps
module vcr_table_load
  import vcr_pkg::*;
#(
  parameter int N = ENTRIES,
  parameter int IW = PHASE_W
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  output logic busy,
  output logic [IW-1:0] idx,
  output logic done
);

  typedef struct packed {
    vcr_ld_state_type st;
    logic [IW-1:0] idx;
    logic done;
  } vcr_ld_type;

  vcr_ld_type s_r;
  vcr_ld_type s_nxt;

  localparam logic [IW-1:0] LAST = IW'(N - 1);

  // A start while copying restarts from entry zero, so the newest
  // table contents always end up in the arbiter.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start)
    begin
      s_nxt.st = LD_COPY;
      s_nxt.idx = '0;
    end
    else
    begin
      unique case (s_r.st)
        LD_IDLE:
        begin
          s_nxt.idx = '0;
        end
        LD_COPY:
        begin
          if (s_r.idx == LAST)
          begin
            s_nxt.st = LD_IDLE;
            s_nxt.idx = '0;
            s_nxt.done = 1'b1;
          end
          else
          begin
            s_nxt.idx = IW'(s_r.idx + 1'b1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '{st: LD_IDLE, idx: '0, done: 1'b0};
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.st == LD_COPY);
  assign idx = s_r.idx;
  assign done = s_r.done;

endmodule
